// File: inc/cexs_map.vh
// Register offsets, field positions, reset values and opcodes of the execution subset
`ifndef CEXS_MAP_VH
`define CEXS_MAP_VH

// Byte offsets on the APB bus
`define CEXS_OFF_CMD       12'h000
`define CEXS_OFF_ACC       12'h004
`define CEXS_OFF_STATUS    12'h008
`define CEXS_OFF_DIR_A     12'h00c
`define CEXS_OFF_DIR_B     12'h010
`define CEXS_OFF_WDOG      12'h014
`define CEXS_OFF_WAKE      12'h018
`define CEXS_OFF_FILE      12'h080

// Command word fields
`define CEXS_CMD_LIT_LSB   0
`define CEXS_CMD_ADDR_LSB  8
`define CEXS_CMD_DEST_BIT  13
`define CEXS_CMD_OP_LSB    16

// Status word bit positions
`define CEXS_ST_CARRY      0
`define CEXS_ST_HCARRY     1
`define CEXS_ST_ZERO       2
`define CEXS_ST_SLEEP_ENT  3
`define CEXS_ST_WD_EXPIRY  4
`define CEXS_ST_SLEEPING   5
`define CEXS_ST_PIN_WAKE   7

// Reset values
`define CEXS_RST_ACC       8'h00
`define CEXS_RST_DIR       8'hff
`define CEXS_RST_WD_EXPIRY 1'b1
`define CEXS_RST_SLEEP_ENT 1'b1

// Opcodes
`define CEXS_OP_SLEEP      4'h0
`define CEXS_OP_ROT_LEFT   4'h1
`define CEXS_OP_ROT_RIGHT  4'h2
`define CEXS_OP_SUBTRACT   4'h3
`define CEXS_OP_SWAP       4'h4
`define CEXS_OP_DIR_LOAD   4'h5
`define CEXS_OP_XOR_FILE   4'h6
`define CEXS_OP_XOR_LIT    4'h7

// Direction register selectors
`define CEXS_DIR_SEL_A     5'h06
`define CEXS_DIR_SEL_B     5'h07

`endif

// File: design/cexs_core.v
// Execution datapath for a subset of an 8-bit core, reached over APB
//
// Notes on behaviour
// - Entering low power clears the watchdog counter and its prescaler.
// - Entering low power sets the watchdog expiry flag and clears the sleep entered flag.
// - Entering low power leaves the pin change wake flag alone.
// - After entering low power the core halts with its oscillator stopped until woken.
// - Rotate left moves old carry into bit 0 and bit 7 into carry, touching only carry.
// - Rotate right moves old carry into bit 7 and bit 0 into carry, touching only carry.
// - Subtract computes file minus accumulator and updates carry, half carry and zero.
// - Destination 0 sends the result to the accumulator, 1 back to file register 0 to 31.
// - Nibble swap exchanges the two halves of the file register and changes no flags.
// - Direction load copies the accumulator into direction register 6 or 7, no flags.
// - Xor with file combines accumulator and file, to the destination, zero flag only.
// - Xor with literal combines accumulator and an 8-bit literal into the accumulator, zero only.
`timescale 1ns/1ns
`default_nettype none
`include "cexs_map.vh"

module cexs_core #(
    parameter WD_PRE_W = 8,
    parameter WD_CNT_W = 8
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Pins
    input  wire        pin_change_in,
    output reg  [7:0]  pin_direction_a,
    output reg  [7:0]  pin_direction_b,
    output reg         osc_stopped
);

    // Zero detect, shared by all instruction zero flag updates
    function zero_of;
        input [7:0] v;
        begin
            zero_of = (v == 8'h00);
        end
    endfunction

    reg  [7:0]          acc_q;
    reg                 carry_q;
    reg                 hcarry_q;
    reg                 zero_q;
    reg                 wd_expiry_q;
    reg                 sleep_ent_q;
    reg                 pin_wake_q;
    reg  [WD_PRE_W-1:0] wd_pre_q;
    reg  [WD_CNT_W-1:0] wd_cnt_q;
    reg                 pin_s1_q;
    reg                 pin_s2_q;
    reg                 pin_s3_q;
    reg  [7:0]          file_mem [0:31];

    wire       acc_phase = psel & penable & pready;
    wire       wr_acc_ph = acc_phase & pwrite;
    wire       cmd_wr    = wr_acc_ph & (paddr == `CEXS_OFF_CMD);
    wire [11:0] file_base = `CEXS_OFF_FILE;
    wire       file_sel  = (paddr[11:7] == file_base[11:7]) & (paddr[1:0] == 2'b00);
    wire [4:0] file_idx  = paddr[6:2];
    wire       pin_rise  = pin_s2_q & ~pin_s3_q;

    // Command fields
    wire [7:0] lit   = pwdata[`CEXS_CMD_LIT_LSB +: 8];
    wire [4:0] faddr = pwdata[`CEXS_CMD_ADDR_LSB +: 5];
    wire       dest  = pwdata[`CEXS_CMD_DEST_BIT];
    wire [3:0] op    = pwdata[`CEXS_CMD_OP_LSB +: 4];
    wire [7:0] fval  = file_mem[faddr];

    // Commands are refused while the oscillator is stopped
    wire       exec  = cmd_wr & ~osc_stopped;

    // Subtraction as f + ~W + 1; carry out means no borrow
    wire [8:0] diff  = {1'b0, fval} + {1'b0, ~acc_q} + 9'h001;
    wire [4:0] hdiff = {1'b0, fval[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;

    reg  [7:0] res;
    reg        res_to_acc;
    reg        res_to_file;
    reg        new_c;
    reg        upd_c;
    reg        upd_hc;
    reg        upd_z;
    reg        do_sleep;
    reg        dir_a_ld;
    reg        dir_b_ld;

    // Instruction decode and result selection
    always @* begin
        res         = 8'h00;
        res_to_acc  = 1'b0;
        res_to_file = 1'b0;
        new_c       = carry_q;
        upd_c       = 1'b0;
        upd_hc      = 1'b0;
        upd_z       = 1'b0;
        do_sleep    = 1'b0;
        dir_a_ld    = 1'b0;
        dir_b_ld    = 1'b0;
        if (exec) begin
            case (op)
                `CEXS_OP_SLEEP: begin
                    do_sleep = 1'b1;
                end
                `CEXS_OP_ROT_LEFT: begin
                    res   = {fval[6:0], carry_q};
                    new_c = fval[7];
                    upd_c = 1'b1;
                end
                `CEXS_OP_ROT_RIGHT: begin
                    res   = {carry_q, fval[7:1]};
                    new_c = fval[0];
                    upd_c = 1'b1;
                end
                `CEXS_OP_SUBTRACT: begin
                    res    = diff[7:0];
                    new_c  = diff[8];
                    upd_c  = 1'b1;
                    upd_hc = 1'b1;
                    upd_z  = 1'b1;
                end
                `CEXS_OP_SWAP: begin
                    res = {fval[3:0], fval[7:4]};
                end
                `CEXS_OP_DIR_LOAD: begin
                    dir_a_ld = (faddr == `CEXS_DIR_SEL_A);
                    dir_b_ld = (faddr == `CEXS_DIR_SEL_B);
                end
                `CEXS_OP_XOR_FILE: begin
                    res   = acc_q ^ fval;
                    upd_z = 1'b1;
                end
                `CEXS_OP_XOR_LIT: begin
                    res   = acc_q ^ lit;
                    upd_z = 1'b1;
                end
                default: begin
                    res = 8'h00;
                end
            endcase
            // File-register operations honour the destination bit
            if (op == `CEXS_OP_XOR_LIT) begin
                res_to_acc = 1'b1;
            end else if (op >= `CEXS_OP_ROT_LEFT && op <= `CEXS_OP_SWAP || op == `CEXS_OP_XOR_FILE) begin
                res_to_acc  = ~dest;
                res_to_file = dest;
            end
        end
    end

    // Input synchroniser for the pin change line
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_change_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // File registers; no reset, like plain data memory
    always @(posedge pclk) begin
        if (res_to_file) begin
            file_mem[faddr] <= res;
        end else if (wr_acc_ph && file_sel) begin
            file_mem[file_idx] <= pwdata[7:0];
        end
    end

    // Accumulator and arithmetic flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q    <= `CEXS_RST_ACC;
            carry_q  <= 1'b0;
            hcarry_q <= 1'b0;
            zero_q   <= 1'b0;
        end else begin
            if (res_to_acc) begin
                acc_q <= res;
            end else if (wr_acc_ph && paddr == `CEXS_OFF_ACC) begin
                acc_q <= pwdata[7:0];
            end
            if (exec) begin
                if (upd_c) begin
                    carry_q <= new_c;
                end
                if (upd_hc) begin
                    hcarry_q <= hdiff[4];
                end
                if (upd_z) begin
                    zero_q <= zero_of(res);
                end
            end else if (wr_acc_ph && paddr == `CEXS_OFF_STATUS) begin
                carry_q  <= pwdata[`CEXS_ST_CARRY];
                hcarry_q <= pwdata[`CEXS_ST_HCARRY];
                zero_q   <= pwdata[`CEXS_ST_ZERO];
            end
        end
    end

    // Power and wake flags; a pin edge wins over a software clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_expiry_q <= `CEXS_RST_WD_EXPIRY;
            sleep_ent_q <= `CEXS_RST_SLEEP_ENT;
            pin_wake_q  <= 1'b0;
            osc_stopped <= 1'b0;
        end else begin
            if (do_sleep) begin
                wd_expiry_q <= 1'b1;
            end else if (&wd_cnt_q && &wd_pre_q) begin
                wd_expiry_q <= 1'b0;
            end else if (wr_acc_ph && paddr == `CEXS_OFF_STATUS) begin
                wd_expiry_q <= pwdata[`CEXS_ST_WD_EXPIRY];
            end
            // Kept apart so a watchdog overflow cannot swallow a software write
            if (do_sleep) begin
                sleep_ent_q <= 1'b0;
            end else if (wr_acc_ph && paddr == `CEXS_OFF_STATUS) begin
                sleep_ent_q <= pwdata[`CEXS_ST_SLEEP_ENT];
            end
            // Sleep never writes this flag
            if (pin_rise) begin
                pin_wake_q <= 1'b1;
            end else if (wr_acc_ph && paddr == `CEXS_OFF_STATUS) begin
                pin_wake_q <= pwdata[`CEXS_ST_PIN_WAKE];
            end
            // Halt until a wake write, a pin edge or a watchdog expiry
            if (do_sleep) begin
                osc_stopped <= 1'b1;
            end else if (pin_rise || (&wd_cnt_q && &wd_pre_q) ||
                         (wr_acc_ph && paddr == `CEXS_OFF_WAKE)) begin
                osc_stopped <= 1'b0;
            end
        end
    end

    // Watchdog: prescaler carries into the counter; it keeps counting on pclk in sleep
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_pre_q <= {WD_PRE_W{1'b0}};
            wd_cnt_q <= {WD_CNT_W{1'b0}};
        end else if (do_sleep) begin
            wd_pre_q <= {WD_PRE_W{1'b0}};
            wd_cnt_q <= {WD_CNT_W{1'b0}};
        end else begin
            wd_pre_q <= wd_pre_q + {{(WD_PRE_W-1){1'b0}}, 1'b1};
            if (&wd_pre_q) begin
                wd_cnt_q <= wd_cnt_q + {{(WD_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Direction registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction_a <= `CEXS_RST_DIR;
            pin_direction_b <= `CEXS_RST_DIR;
        end else begin
            if (dir_a_ld) begin
                pin_direction_a <= acc_q;
            end
            if (dir_b_ld) begin
                pin_direction_b <= acc_q;
            end
        end
    end

    // APB answer: data and ready are set up in the setup cycle, so no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                if (file_sel) begin
                    prdata <= {24'h00_0000, file_mem[file_idx]};
                end else begin
                    case (paddr)
                        `CEXS_OFF_CMD:    prdata <= 32'h0000_0000;
                        `CEXS_OFF_ACC:    prdata <= {24'h00_0000, acc_q};
                        `CEXS_OFF_STATUS: prdata <= {24'h00_0000, pin_wake_q, 1'b0, osc_stopped,
                                                     wd_expiry_q, sleep_ent_q, zero_q, hcarry_q, carry_q};
                        `CEXS_OFF_DIR_A:  prdata <= {24'h00_0000, pin_direction_a};
                        `CEXS_OFF_DIR_B:  prdata <= {24'h00_0000, pin_direction_b};
                        `CEXS_OFF_WDOG:   prdata <= {{(32-WD_CNT_W){1'b0}}, wd_cnt_q};
                        `CEXS_OFF_WAKE:   prdata <= 32'h0000_0000;
                        default:          pslverr <= 1'b1; // Unmapped address
                    endcase
                end
            end
        end
    end

endmodule

`default_nettype wire

// File: bench/cexs_monitor.sv
// Port-level assertions for the execution subset and its APB slave
`timescale 1ns/1ns
`default_nettype none
`include "cexs_map.vh"
module cexs_monitor (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Pins
    input wire [7:0]  pin_direction_a,
    input wire [7:0]  pin_direction_b,
    input wire        osc_stopped
);
    // Command write landing at the access edge
    wire       cmd_wr = psel && penable && pready && pwrite && paddr == `CEXS_OFF_CMD;
    wire [3:0] op     = pwdata[`CEXS_CMD_OP_LSB +: 4];
    wire [4:0] sel    = pwdata[`CEXS_CMD_ADDR_LSB +: 5];
    wire       mapped = paddr <= `CEXS_OFF_WAKE && paddr[1:0] == 2'h0 || paddr >= `CEXS_OFF_FILE && paddr[1:0] == 2'h0
                        && paddr <= 12'h0fc;
    // Causes kept one cycle, since their effect shows a cycle later
    reg        sleep_q;
    reg        load_a_q;
    reg        load_b_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_q  <= 1'b0;
            load_a_q <= 1'b0;
            load_b_q <= 1'b0;
        end else begin
            sleep_q  <= cmd_wr && op == `CEXS_OP_SLEEP;
            load_a_q <= cmd_wr && !osc_stopped && op == `CEXS_OP_DIR_LOAD && sel == `CEXS_DIR_SEL_A;
            load_b_q <= cmd_wr && !osc_stopped && op == `CEXS_OP_DIR_LOAD && sel == `CEXS_DIR_SEL_B;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next:    assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_single:  assert property (pready |=> !pready) else $error("ready held too long");
    a_rdata_idle:    assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    a_err_unmapped:  assert property (pready |-> pslverr == !mapped) else $error("error flag wrong");
    a_read_upper:    assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    a_sleep_halts:   assert property (cmd_wr && op == `CEXS_OP_SLEEP && !osc_stopped |=> osc_stopped)
        else $error("no halt after sleep");
    a_halt_cause:    assert property ($rose(osc_stopped) |-> sleep_q) else $error("halt without sleep");
    a_dir_a_cause:   assert property ($changed(pin_direction_a) |-> load_a_q)
        else $error("direction a changed");
    a_dir_b_cause:   assert property ($changed(pin_direction_b) |-> load_b_q)
        else $error("direction b changed");
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the execution subset over APB
`timescale 1ns/1ns
`default_nettype none
`include "cexs_map.vh"
module tb_top;
    reg         pclk;
    reg         presetn;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg         pin_change_in;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        osc_stopped;
    wire [7:0]  pin_direction_a;
    wire [7:0]  pin_direction_b;
    reg  [31:0] rd;
    reg         err;
    integer     n_errors;
    integer     total_checks;
    integer     i;
    reg  [7:0]  sf [0:2];
    reg  [7:0]  sa [0:2];
    reg  [7:0]  sr [0:2];
    reg  [7:0]  ss [0:2];
    cexs_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
                   .pin_change_in, .pin_direction_a, .pin_direction_b, .osc_stopped);
    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // One transfer; the request stays put until pready is seen
    task xfer(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [11:0] a, input [7:0] v);
        xfer(1'b1, a, {24'h0, v});
    endtask
    task rc(input [11:0] a, input [7:0] v);
        begin
            xfer(1'b0, a, 32'h0);
            chk(rd, {24'h0, v});
        end
    endtask
    // Command word: op, destination, file address, literal
    task ex(input [3:0] op, input [4:0] f, input dst, input [7:0] k);
        xfer(1'b1, `CEXS_OFF_CMD, {12'h0, op, 2'h0, dst, f, k});
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    // Hang guard, far beyond the thousand or so cycles the tests need
    initial begin
        #200000;
        n_errors = n_errors + 1;
        give_verdict;
    end
    initial begin
        {psel, penable, pwrite, pin_change_in, paddr, pwdata} = 0;
        {n_errors, total_checks} = 0;
        presetn = 1'b0;
        sf = '{8'h10, 8'h05, 8'h05};
        sa = '{8'h01, 8'h05, 8'h13};
        sr = '{8'h0f, 8'h00, 8'hf2};
        ss = '{8'h01, 8'h07, 8'h02};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rc(`CEXS_OFF_STATUS, 8'h18);
        rc(`CEXS_OFF_DIR_A, 8'hff);
        // Unmapped offset: error, no data
        xfer(1'b0, 12'h01c, 32'h0);
        chk({rd[31:1], err}, 32'h1);
        wr(12'h094, 8'h81);
        wr(`CEXS_OFF_STATUS, 8'h04);
        ex(`CEXS_OP_ROT_LEFT, 5'h05, 1'b1, 8'h00);
        rc(12'h094, 8'h02);
        rc(`CEXS_OFF_STATUS, 8'h05);
        ex(`CEXS_OP_ROT_RIGHT, 5'h05, 1'b0, 8'h00);
        rc(`CEXS_OFF_ACC, 8'h81);
        rc(12'h094, 8'h02);
        rc(`CEXS_OFF_STATUS, 8'h04);
        // Subtract into the last file register, borrow and nibble cases
        for (i = 0; i < 3; i = i + 1) begin
            wr(`CEXS_OFF_ACC, sa[i]);
            wr(12'h0fc, sf[i]);
            wr(`CEXS_OFF_STATUS, 8'h00);
            ex(`CEXS_OP_SUBTRACT, 5'h1f, 1'b1, 8'h00);
            rc(12'h0fc, sr[i]);
            rc(`CEXS_OFF_STATUS, ss[i]);
            rc(`CEXS_OFF_ACC, sa[i]);
        end
        wr(`CEXS_OFF_FILE, 8'ha5);
        wr(`CEXS_OFF_STATUS, 8'h07);
        ex(`CEXS_OP_SWAP, 5'h00, 1'b0, 8'h00);
        rc(`CEXS_OFF_ACC, 8'h5a);
        rc(`CEXS_OFF_STATUS, 8'h07);
        wr(12'h088, 8'h3c);
        wr(`CEXS_OFF_ACC, 8'h3c);
        wr(`CEXS_OFF_STATUS, 8'h03);
        ex(`CEXS_OP_XOR_FILE, 5'h02, 1'b1, 8'h00);
        rc(12'h088, 8'h00);
        rc(`CEXS_OFF_STATUS, 8'h07);
        wr(`CEXS_OFF_ACC, 8'h0f);
        ex(`CEXS_OP_XOR_LIT, 5'h00, 1'b0, 8'hff);
        rc(`CEXS_OFF_ACC, 8'hf0);
        rc(`CEXS_OFF_STATUS, 8'h03);
        // Direction loads, then a selector that must do nothing
        wr(`CEXS_OFF_ACC, 8'h12);
        ex(`CEXS_OP_DIR_LOAD, `CEXS_DIR_SEL_A, 1'b0, 8'h00);
        wr(`CEXS_OFF_ACC, 8'h34);
        ex(`CEXS_OP_DIR_LOAD, `CEXS_DIR_SEL_B, 1'b0, 8'h00);
        ex(`CEXS_OP_DIR_LOAD, 5'h05, 1'b0, 8'h00);
        // Undefined opcode must be a no-op
        ex(4'h8, 5'h05, 1'b1, 8'hff);
        rc(`CEXS_OFF_STATUS, 8'h03);
        chk({pin_direction_a, pin_direction_b}, 32'h1234);
        // Pin edge sets the wake flag; the long wait lets the watchdog count up
        wr(`CEXS_OFF_STATUS, 8'h08);
        pin_change_in <= 1'b1;
        repeat (600) @(posedge pclk);
        rc(`CEXS_OFF_STATUS, 8'h88);
        xfer(1'b0, `CEXS_OFF_WDOG, 32'h0);
        chk({31'h0, |rd[7:0]}, 32'h1);
        ex(`CEXS_OP_SLEEP, 5'h00, 1'b0, 8'h00);
        rc(`CEXS_OFF_STATUS, 8'hb0);
        rc(`CEXS_OFF_WDOG, 8'h00);
        chk(osc_stopped, 32'h1);
        ex(`CEXS_OP_DIR_LOAD, `CEXS_DIR_SEL_A, 1'b0, 8'h00);
        rc(`CEXS_OFF_DIR_A, 8'h12);
        wr(`CEXS_OFF_WAKE, 8'h00);
        rc(`CEXS_OFF_STATUS, 8'h90);
        chk(osc_stopped, 32'h0);
        give_verdict;
    end
endmodule
bind cexs_core cexs_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                                 .pslverr, .pin_direction_a, .pin_direction_b, .osc_stopped);
`default_nettype wire
